// *** rtl/vcr_osc_cal.sv ***
// Purpose: Oscillator calibration registers and trim search engine.
// Assumes: osc_fast compares oscillator against reference times divider ratio, from the synthesizer.
// Notes: Binary search over seven trim bits, one settle wait per step.
`include "vcr_defines.svh"
`default_nettype none
module vcr_osc_cal
   import vcr_pkg::*;
#(
   parameter int SETTLE_BASE_CYC = `VCR_SETTLE_BASE_CYC
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic osc_fast,
   output logic [6:0] osc_trim_code,
   output logic synth_hold_bit,
   output logic osc_cal_complete,
   output logic cal_busy
);
   vcr_wr_s wr;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   vcr_cfg_s cfg_q, cfg_d;
   vcr_cal_e st_q, st_d;
   logic [6:0] bit_q, bit_d;
   logic [15:0] wait_q, wait_d;
   logic done_q, done_d;
   logic [2:0] fast_q, fast_d;
   logic fast_s;

   function automatic logic [15:0] settle_cycles(input logic [2:0] sel);
      settle_cycles = 16'(SETTLE_BASE_CYC) << sel;
   endfunction

   vcr_spi_port u_port (
      .clock(clock),
      .rst_n(rst_n),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe_n(spi_sdo_oe_n),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .wr(wr)
   );

   always_comb
   begin
      if (rd_addr == `VCR_ADDR_TRIM)
         rd_data = {1'b0, cfg_q.trim};
      else if (rd_addr == `VCR_ADDR_HOLD)
         rd_data = {7'h00, cfg_q.hold};
      else if (rd_addr == `VCR_ADDR_CTRL)
         rd_data = {1'b0, cfg_q.settle_sel, 3'h0, cfg_q.cal_en};
      else if (rd_addr == `VCR_ADDR_STAT)
         rd_data = {7'h00, done_q};
      else
         rd_data = 8'h00;
   end

   always_comb
   begin
      fast_d = {fast_q[1:0], osc_fast};
      fast_s = fast_q[2];
      if (fast_q[1] == fast_q[2])
         fast_s = fast_q[1];
      cfg_d = cfg_q;
      st_d = st_q;
      bit_d = bit_q;
      wait_d = wait_q;
      done_d = done_q;
      if (wr.we && wr.addr == `VCR_ADDR_TRIM && st_q != CAL_SETTLE && st_q != CAL_DECIDE)
         cfg_d.trim = wr.wdata[`VCR_TRIM_MSB:0];
      if (wr.we && wr.addr == `VCR_ADDR_HOLD)
         cfg_d.hold = wr.wdata[`VCR_HOLD_BIT];
      if (wr.we && wr.addr == `VCR_ADDR_CTRL)
      begin
         cfg_d.cal_en = wr.wdata[`VCR_EN_BIT];
         cfg_d.settle_sel = wr.wdata[`VCR_STL_MSB:`VCR_STL_LSB];
      end
      case (st_q)
         CAL_IDLE:
         begin
            done_d = !cfg_q.cal_en;
            if (cfg_q.hold && wr.we && wr.addr == `VCR_ADDR_HOLD && !wr.wdata[`VCR_HOLD_BIT] && cfg_q.cal_en)
            begin
               st_d = CAL_SETTLE;
               bit_d = 7'h40;
               cfg_d.trim = 7'h40;
               wait_d = settle_cycles(cfg_q.settle_sel);
               done_d = 1'b0;
            end
            else if (!cfg_q.hold && !cfg_q.cal_en)
               done_d = 1'b1;
         end
         CAL_SETTLE:
         begin
            wait_d = wait_q - 16'h0001;
            if (wait_q <= 16'h0001)
               st_d = CAL_DECIDE;
         end
         CAL_DECIDE:
         begin
            st_d = CAL_SETTLE;
            wait_d = settle_cycles(cfg_q.settle_sel);
            bit_d = bit_q >> 1;
            cfg_d.trim = cfg_q.trim;
            if (fast_s)
               cfg_d.trim = cfg_q.trim & ~bit_q;
            cfg_d.trim = cfg_d.trim | (bit_q >> 1);
            if (bit_q == 7'h01)
            begin
               st_d = CAL_DONE;
               wait_d = 16'h0000;
            end
         end
         default:
         begin
            done_d = 1'b1;
            if (cfg_q.hold)
               st_d = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cfg_q <= {`VCR_RST_TRIM, `VCR_RST_HOLD, `VCR_RST_EN, `VCR_RST_STL};
         st_q <= CAL_IDLE;
         bit_q <= 7'h00;
         wait_q <= 16'h0000;
         done_q <= 1'b0;
         fast_q <= 3'h0;
      end
      else
      begin
         cfg_q <= cfg_d;
         st_q <= st_d;
         bit_q <= bit_d;
         wait_q <= wait_d;
         done_q <= done_d;
         fast_q <= fast_d;
      end
   end

   assign osc_trim_code = cfg_q.trim;
   assign synth_hold_bit = cfg_q.hold;
   assign osc_cal_complete = done_q;
   assign cal_busy = (st_q == CAL_SETTLE) || (st_q == CAL_DECIDE);
endmodule // vcr_osc_cal
`default_nettype wire

// *** rtl/vcr_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the oscillator calibration registers.
// Assumes: Byte-wide registers on the serial register port, 250 MHz core clock.
// Notes on behaviour
// - A 7-bit read/write trim field in the low bits sets oscillator frequency.
// - A running calibration writes its result into the trim field automatically.
// - After calibration the trim reads the calibrated code and software may rewrite it.
// - A 3-bit settle field, reset 4, sets the wait per trim step; larger is longer.
// - Bit 0 of the calibration control register enables the calibration engine.
// - With calibration enabled, writing the hold bit from one to zero starts calibration.
// - The engine searches the trim code to centre the oscillator frequency.
// - Status bit 0 reads one once calibration has finished.
// - With calibration disabled the done flag also reads one.
// - The status register at 0x5E is read-only and ignores writes.
// - All registers are reached through the serial register port.
`ifndef VCR_DEFINES_SVH
`define VCR_DEFINES_SVH

`define VCR_ADDR_TRIM 7'h59
`define VCR_ADDR_HOLD 7'h5C
`define VCR_ADDR_CTRL 7'h5D
`define VCR_ADDR_STAT 7'h5E

`define VCR_TRIM_MSB 6
`define VCR_HOLD_BIT 0
`define VCR_EN_BIT 0
`define VCR_STL_LSB 4
`define VCR_STL_MSB 6
`define VCR_DONE_BIT 0

`define VCR_RST_TRIM 7'h00
`define VCR_RST_HOLD 1'b0
`define VCR_RST_EN 1'b0
`define VCR_RST_STL 3'h4

// Base settle time in nanoseconds and its count at 250 MHz; the code doubles it per settle step.
`define VCR_SETTLE_BASE_NS 64
`define VCR_CLK_PERIOD_NS 4
`define VCR_SETTLE_BASE_CYC (`VCR_SETTLE_BASE_NS / `VCR_CLK_PERIOD_NS)

`endif

// *** rtl/vcr_pkg.sv ***
// Purpose: Types shared by the oscillator calibration register block.
// Assumes: Field widths are written here as literals and match the defines.
// Notes: Only types live here.
`default_nettype none
package vcr_pkg;
   typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_DECIDE, CAL_DONE} vcr_cal_e;
   typedef struct packed {
      logic [6:0] trim;
      logic hold;
      logic cal_en;
      logic [2:0] settle_sel;
   } vcr_cfg_s;
   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] wdata;
   } vcr_wr_s;
endpackage
`default_nettype wire

// *** rtl/vcr_spi_port.sv ***
// Purpose: Serial register port slave; three-wire style, 16-bit frames.
// Assumes: Frame is R/W bit, 7-bit address, 8 data bits, MSB first, sampled on rising sclk, mode 0.
// Notes: Pins pass a three-stage synchroniser; edges count when stages two and three differ.
`include "vcr_defines.svh"
`default_nettype none
module vcr_spi_port
   import vcr_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   output logic [6:0] rd_addr,
   input wire logic [7:0] rd_data,
   output vcr_wr_s wr
);
   logic [2:0] sclk_q, sclk_d, cs_q, cs_d, sdi_q, sdi_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic [7:0] out_q, out_d;
   logic sdo_q, sdo_d, oe_n_q, oe_n_d;
   vcr_wr_s wr_q, wr_d;
   logic rise, fall, active;

   always_comb
   begin
      sclk_d = {sclk_q[1:0], spi_sclk};
      cs_d = {cs_q[1:0], spi_cs_n};
      sdi_d = {sdi_q[1:0], spi_sdi};
      active = !cs_q[1] && !cs_q[2];
      rise = sclk_q[1] && sclk_q[2] == 1'b0 && active;
      fall = !sclk_q[1] && sclk_q[2] && active;
      cnt_d = cnt_q;
      sh_d = sh_q;
      out_d = out_q;
      sdo_d = sdo_q;
      oe_n_d = oe_n_q;
      wr_d = '0;
      if (!active)
      begin
         cnt_d = 5'h00;
         oe_n_d = 1'b1;
      end
      else if (rise && cnt_q != 5'h10)
      begin
         sh_d = {sh_q[14:0], sdi_q[2]};
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == 5'h0F && !sh_q[14])
         begin
            wr_d.we = 1'b1;
            wr_d.addr = sh_q[13:7];
            wr_d.wdata = {sh_q[6:0], sdi_q[2]};
         end
      end
      else if (fall && cnt_q == 5'h08 && sh_q[7])
      begin
         out_d = rd_data;
         sdo_d = rd_data[7];
         oe_n_d = 1'b0;
      end
      else if (fall && cnt_q > 5'h08 && cnt_q < 5'h10)
      begin
         out_d = {out_q[6:0], 1'b0};
         sdo_d = out_q[6];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sclk_q <= 3'h0;
         cs_q <= 3'h7;
         sdi_q <= 3'h0;
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         out_q <= 8'h00;
         sdo_q <= 1'b0;
         oe_n_q <= 1'b1;
         wr_q <= '0;
      end
      else
      begin
         sclk_q <= sclk_d;
         cs_q <= cs_d;
         sdi_q <= sdi_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         out_q <= out_d;
         sdo_q <= sdo_d;
         oe_n_q <= oe_n_d;
         wr_q <= wr_d;
      end
   end

   assign rd_addr = sh_q[6:0];
   assign spi_sdo = sdo_q;
   assign spi_sdo_oe_n = oe_n_q;
   assign wr = wr_q;
endmodule // vcr_spi_port
`default_nettype wire

// *** sim/vcr_osc_cal_sva.sv ***
// Purpose: Port assertions for the oscillator calibration block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every vcr_osc_cal instance.
`default_nettype none
module vcr_osc_cal_sva
   import vcr_pkg::*;
#(
   parameter int SETTLE_BASE_CYC = 16
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe_n,
   input wire logic osc_fast,
   input wire logic [6:0] osc_trim_code,
   input wire logic synth_hold_bit,
   input wire logic osc_cal_complete,
   input wire logic cal_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence cal_start_s;
      $rose(cal_busy);
   endsequence
   sequence cal_end_s;
      $fell(cal_busy);
   endsequence
   busy_not_done_a: assert property (cal_busy |-> !osc_cal_complete) else $error("done in search");
   end_sets_done_a: assert property (cal_end_s |-> ##[0:1] osc_cal_complete) else $error("no done");
   start_hold_low_a: assert property (cal_start_s |-> !synth_hold_bit) else $error("start in hold");
   start_mid_trim_a: assert property (cal_start_s |-> ##[0:2] osc_trim_code == 7'h40) else $error("bad seed");
   settle_min_a: assert property (cal_start_s |-> cal_busy [*8]) else $error("search short");
   trim_step_gap_a: assert property (cal_busy && $changed(osc_trim_code) |=> $stable(osc_trim_code))
      else $error("trim moved twice");
   sdo_idle_off_a: assert property (spi_cs_n [*8] |-> spi_sdo_oe_n) else $error("sdo on idle");
   reset_done_a: assert property ($rose(rst_n) |-> ##[0:2] osc_cal_complete) else $error("no skip done");
endmodule // vcr_osc_cal_sva
bind vcr_osc_cal vcr_osc_cal_sva #(.SETTLE_BASE_CYC(SETTLE_BASE_CYC)) u_sva (.clock(clock), .rst_n(rst_n),
   .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
   .osc_fast(osc_fast), .osc_trim_code(osc_trim_code), .synth_hold_bit(synth_hold_bit),
   .osc_cal_complete(osc_cal_complete), .cal_busy(cal_busy));
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Register-level test of the oscillator calibration block.
// Assumes: Oscillator modelled as fast when trim exceeds a target.
// Notes: Short settle base keeps runs brief.
`include "vcr_defines.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import vcr_pkg::*;
   // The base settle must outlast the three-cycle lag of the synchronised fast flag.
   localparam int SB = 4;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic spi_sclk = 1'b0;
   logic spi_cs_n = 1'b1;
   logic spi_sdi = 1'b0;
   logic osc_fast = 1'b0;
   logic spi_sdo, spi_sdo_oe_n, synth_hold_bit, osc_cal_complete, cal_busy;
   logic [6:0] osc_trim_code;
   logic [6:0] tgt = 7'h00;
   logic [7:0] rd_q = 8'h00;
   logic oe_q = 1'b1;
   int error_cnt = 0;
   int compares = 0;
   int busy_cyc = 0;
   int last_cyc = 0;
   vcr_osc_cal #(.SETTLE_BASE_CYC(SB)) u_dut (.clock(clock), .rst_n(rst_n), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
      .osc_fast(osc_fast), .osc_trim_code(osc_trim_code), .synth_hold_bit(synth_hold_bit),
      .osc_cal_complete(osc_cal_complete), .cal_busy(cal_busy));
   initial
   begin
      forever #2 clock = ~clock;
   end
   always @(negedge clock) osc_fast <= (osc_trim_code > tgt);
   always @(posedge clock) if (cal_busy === 1'b1) busy_cyc++;
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [15:0] f);
      spi_cs_n = 1'b0;
      tick(8);
      for (int i = 15; i >= 0; i--)
      begin
         spi_sdi = f[i];
         tick(8);
         if (i < 8) rd_q[i] = spi_sdo;
         if (i == 0) oe_q = spi_sdo_oe_n;
         spi_sclk = 1'b1;
         tick(8);
         spi_sclk = 1'b0;
      end
      tick(8);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      tick(12);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      xfer({1'b0, a, d});
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      xfer({1'b1, a, 8'h00});
      chk(rd_q, e);
      chk({6'h00, oe_q, spi_sdo_oe_n}, 8'h01);
   endtask
   task automatic tally_and_finish();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clock);
      error_cnt++;
      tally_and_finish();
   end
   initial
   begin
      tick(3);
      rst_n = 1'b1;
      tick(4);
      chk({7'h00, osc_cal_complete}, 8'h01);
      rd(`VCR_ADDR_TRIM, 8'h00);
      rd(`VCR_ADDR_HOLD, 8'h00);
      rd(`VCR_ADDR_CTRL, 8'h40);
      rd(7'h5A, 8'h00);
      wr(`VCR_ADDR_STAT, 8'h00);
      rd(`VCR_ADDR_STAT, 8'h01);
      wr(`VCR_ADDR_TRIM, 8'h2A);
      rd(`VCR_ADDR_TRIM, 8'h2A);
      chk({1'b0, osc_trim_code}, 8'h2A);
      for (int k = 0; k < 2; k++)
      begin
         tgt = k ? 7'h4A : 7'h35;
         wr(`VCR_ADDR_HOLD, 8'h01);
         chk({7'h00, synth_hold_bit}, 8'h01);
         wr(`VCR_ADDR_CTRL, k ? 8'h71 : 8'h01);
         rd(`VCR_ADDR_CTRL, k ? 8'h71 : 8'h01);
         chk({6'h00, cal_busy, osc_cal_complete}, 8'h00);
         busy_cyc = 0;
         wr(`VCR_ADDR_HOLD, 8'h00);
         for (int n = 0; n < 6000 && osc_cal_complete !== 1'b1; n++) tick(1);
         chk({6'h00, synth_hold_bit, osc_cal_complete}, 8'h01);
         chk({1'b0, osc_trim_code}, {1'b0, tgt});
         rd(`VCR_ADDR_TRIM, {1'b0, tgt});
         rd(`VCR_ADDR_STAT, 8'h01);
         chk({7'h00, busy_cyc >= 7 * (SB << (k * 7)) && busy_cyc > last_cyc}, 8'h01);
         last_cyc = busy_cyc;
      end
      wr(`VCR_ADDR_TRIM, 8'h11);
      rd(`VCR_ADDR_TRIM, 8'h11);
      wr(`VCR_ADDR_HOLD, 8'h01);
      wr(`VCR_ADDR_CTRL, 8'h40);
      wr(`VCR_ADDR_HOLD, 8'h00);
      rd(`VCR_ADDR_STAT, 8'h01);
      rd(`VCR_ADDR_TRIM, 8'h11);
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      tick(4);
      chk({osc_trim_code, synth_hold_bit}, 8'h00);
      chk({7'h00, osc_cal_complete}, 8'h01);
      rd(`VCR_ADDR_CTRL, 8'h40);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
